// ### src/gpio_notify.sv
// Overview of operation
// - Writing one to a set bit drives that output pin high.
// - Writing one to a clear bit drives that output pin low.
// - Set and clear never touch pins given to an alternate function.
// - Set and clear never touch pins whose direction is input.
// - The level register reads the present level of all ten pins.
// - Writing the level register loads every general purpose output pin.
// - Unmasked input changes trigger a packet; the mask resets to 0x100.
// - The mask covers every input pin, alternate function ones too.
// - Masked pins are still read and reported in the vendor packet, and ring, DSR and DCD in the standard one.
// - With the break enable bit set a received break triggers a packet.
// - Format bit zero picks the standard or the vendor packet layout.
// - Standard packet opens with request type 0xA1 and code 0x20.
// - Then zero value, zero index, length two, two data bytes, low first.
// - Data bits: overrun, parity, framing, ring, break, DSR, DCD.
// - Vendor packet: two level bytes then two change-flag bytes.
// - Vendor packet ends with an error and break status byte.
// - Direction bit one makes a general purpose pin an output.
`timescale 1ns/100ps
module gpio_notify import gpio_notify_pkg::*; #(
  parameter int DCD_PIN  = 1,
  parameter int DSR_PIN  = 3,
  parameter int RING_PIN = 0
) (
  input  wire logic              CLK_I,
  input  wire logic              RST_I,
  input  wire logic              CE_I,
  input  wire logic [ADDR_W-1:0] AWADDR_I,
  input  wire logic              AWVALID_I,
  output logic                   AWREADY_O,
  input  wire logic [31:0]       WDATA_I,
  input  wire logic [3:0]        WSTRB_I,
  input  wire logic              WVALID_I,
  output logic                   WREADY_O,
  output logic      [1:0]        BRESP_O,
  output logic                   BVALID_O,
  input  wire logic              BREADY_I,
  input  wire logic [ADDR_W-1:0] ARADDR_I,
  input  wire logic              ARVALID_I,
  output logic                   ARREADY_O,
  output logic      [31:0]       RDATA_O,
  output logic      [1:0]        RRESP_O,
  output logic                   RVALID_O,
  input  wire logic              RREADY_I,
  input  wire logic [NPIN-1:0]   PIN_I,
  output logic      [NPIN-1:0]   PIN_O,
  output logic      [NPIN-1:0]   PIN_OE_O,
  input  wire logic [NPIN-1:0]   ALT_OUT_I,
  input  wire logic [NPIN-1:0]   ALT_OE_I,
  output logic      [NPIN-1:0]   ALT_SEL_O,
  input  wire logic              OVR_I,
  input  wire logic              PAR_I,
  input  wire logic              FRM_I,
  input  wire logic              BRK_I,
  output logic      [7:0]        PKT_DATA_O,
  output logic                   PKT_VALID_O,
  output logic                   PKT_LAST_O,
  input  wire logic              PKT_READY_I,
  output logic                   IRQ_O
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             aw_rdy;
    logic             w_rdy;
    logic             aw_got;
    logic             w_got;
    logic [IDX_W-1:0] awidx;
    logic [REG_W-1:0] wdata;
    logic [1:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             ar_rdy;
    logic             rvalid;
    logic [REG_W-1:0] rdata;
    logic [1:0]       rresp;
    logic [NPIN-1:0]  alt;
    logic [NPIN-1:0]  dir;
    logic [NPIN-1:0]  out;
    logic [NPIN-1:0]  nmask;
    logic [1:0]       fmt;
    logic [NPIN-1:0]  pin_o;
    logic [NPIN-1:0]  pin_oe;
    logic [1:0]       warm;
    logic [NPIN-1:0]  lvl_prev;
    logic             brk_prev;
    logic [NPIN-1:0]  chg;
    logic [NPIN-1:0]  snap;
    logic             pend;
    logic [NEV-1:0]   istat;
    logic [NEV-1:0]   imask;
    logic             irq;
  } st_t;

  localparam st_t ST_RST = '{alt: RST_PIN_MODE, dir: RST_PIN_DIR, out: RST_PIN_OUT,
                             nmask: RST_NOTIFY_MASK, fmt: RST_NOTIFY_FMT,
                             imask: RST_INT_MASK, default: '0};

  st_t st_r;
  st_t st_nxt;

  logic [NPIN-1:0]      lvl_s, gp_out, set_bits, clr_bits, lvl_wm, diff;
  logic                 tx_busy, tx_done, tx_valid, tx_last;
  logic                 aw_fire, w_fire, ar_fire, wr_fire;
  logic                 pin_trig, brk_rise, brk_trig, load;
  logic [7:0]           tx_data, std_data, vnd_stat;
  logic [REG_W-1:0]     wlm;
  logic [IDX_W-1:0]     aridx;
  logic [NEV-1:0]       ist_clr;
  logic [8*PKT_MAX-1:0] pkt_buf;
  logic [LEN_W-1:0]     pkt_len;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  // Pin levels come from outside the clock domain.
  pin_sync #(.W(NPIN)) u_sync (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .ce_i  (CE_I),
    .d_i   (PIN_I),
    .q_o   (lvl_s)
  );

  // Notification packet shifter toward the interrupt endpoint.
  pkt_tx #(.NBYTE(PKT_MAX)) u_tx (
    .clk_i   (CLK_I),
    .rst_i   (RST_I),
    .ce_i    (CE_I),
    .load_i  (load),
    .buf_i   (pkt_buf),
    .len_i   (pkt_len),
    .data_o  (tx_data),
    .valid_o (tx_valid),
    .last_o  (tx_last),
    .ready_i (PKT_READY_I),
    .busy_o  (tx_busy),
    .done_o  (tx_done)
  );

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Bus handshakes and the write that executes once address and data are held.
  assign wlm     = lanes(st_r.wstrb);
  assign aw_fire = AWVALID_I & st_r.aw_rdy;
  assign w_fire  = WVALID_I & st_r.w_rdy;
  assign ar_fire = ARVALID_I & st_r.ar_rdy;
  assign wr_fire = st_r.aw_got & st_r.w_got & ~st_r.bvalid;
  assign aridx   = ARADDR_I[ADDR_W-1:2];

  // Only general purpose pins set as outputs may be steered by software.
  assign gp_out   = ~st_r.alt & st_r.dir;
  assign set_bits = (wr_fire && st_r.awidx == IDX_PIN_SET) ?
                    (st_r.wdata[NPIN-1:0] & wlm[NPIN-1:0] & gp_out) : '0;
  assign clr_bits = (wr_fire && st_r.awidx == IDX_PIN_CLEAR) ?
                    (st_r.wdata[NPIN-1:0] & wlm[NPIN-1:0] & gp_out) : '0;
  assign lvl_wm   = (wr_fire && st_r.awidx == IDX_PIN_LEVEL) ?
                    (wlm[NPIN-1:0] & gp_out) : '0;
  assign ist_clr  = (wr_fire && st_r.awidx == IDX_INT_STATUS) ?
                    (st_r.wdata[NEV-1:0] & wlm[NEV-1:0]) : '0;

  // Change detection on every pin not driven by this device, after warm-up.
  assign diff     = (st_r.warm == WARM_CYC) ?
                    ((lvl_s ^ st_r.lvl_prev) & ~st_r.pin_oe) : '0;
  assign pin_trig = |(diff & ~st_r.nmask);
  assign brk_rise = BRK_I & ~st_r.brk_prev;
  assign brk_trig = brk_rise & st_r.fmt[FMT_BREAK];
  assign load     = st_r.pend & ~tx_busy;

  // ----------------------------------------------------------------
  // Packet assembly
  // ----------------------------------------------------------------
  // Status bytes of the two layouts; ring, DSR and DCD follow their pins.
  always_comb begin
    std_data           = 8'h00;
    std_data[STD_OVR]  = OVR_I;
    std_data[STD_PAR]  = PAR_I;
    std_data[STD_FRM]  = FRM_I;
    std_data[STD_RING] = lvl_s[RING_PIN];
    std_data[STD_BRK]  = BRK_I;
    std_data[STD_DSR]  = lvl_s[DSR_PIN];
    std_data[STD_DCD]  = lvl_s[DCD_PIN];
    vnd_stat           = 8'h00;
    vnd_stat[VND_OVR]  = OVR_I;
    vnd_stat[VND_PAR]  = PAR_I;
    vnd_stat[VND_FRM]  = FRM_I;
    vnd_stat[VND_BRK]  = BRK_I;
  end

  // Byte zero sits in the low bits; multi-byte fields go low byte first.
  always_comb begin
    if (st_r.fmt[FMT_VENDOR]) begin
      pkt_buf = {40'h0, vnd_stat,
                 6'h00, st_r.chg[9:8], st_r.chg[7:0],
                 6'h00, lvl_s[9:8], lvl_s[7:0]};
      pkt_len = PKT_VND_LEN;
    end else begin
      pkt_buf = {8'h00, std_data,
                 PKT_WLENGTH[15:8], PKT_WLENGTH[7:0],
                 8'h00, PKT_IFACE, PKT_WVALUE[15:8], PKT_WVALUE[7:0],
                 PKT_SERIAL_STATE, PKT_REQ_TYPE};
      pkt_len = PKT_STD_LEN;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Write address and data are taken in either order.
    if (aw_fire) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awidx  = AWADDR_I[ADDR_W-1:2];
    end
    if (w_fire) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = WDATA_I[REG_W-1:0];
      st_nxt.wstrb = WSTRB_I[1:0];
    end
    if (st_r.bvalid && BREADY_I) begin
      st_nxt.bvalid = 1'b0;
    end
    // Register writes honour the two low byte strobes.
    if (wr_fire) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = RESP_OKAY;
      case (st_r.awidx)
        IDX_PIN_MODE: begin
          st_nxt.alt = (st_r.alt & ~wlm[NPIN-1:0]) | (st_r.wdata[NPIN-1:0] & wlm[NPIN-1:0]);
        end
        IDX_PIN_DIR: begin
          st_nxt.dir = (st_r.dir & ~wlm[NPIN-1:0]) | (st_r.wdata[NPIN-1:0] & wlm[NPIN-1:0]);
        end
        IDX_NOTIFY_MASK: begin
          st_nxt.nmask = (st_r.nmask & ~wlm[NPIN-1:0]) |
                         (st_r.wdata[NPIN-1:0] & wlm[NPIN-1:0]);
        end
        IDX_NOTIFY_FMT: begin
          st_nxt.fmt = (st_r.fmt & ~wlm[1:0]) | (st_r.wdata[1:0] & wlm[1:0]);
        end
        IDX_INT_MASK: begin
          st_nxt.imask = (st_r.imask & ~wlm[NEV-1:0]) | (st_r.wdata[NEV-1:0] & wlm[NEV-1:0]);
        end
        IDX_PIN_SET, IDX_PIN_CLEAR, IDX_PIN_LEVEL, IDX_INT_STATUS: begin
          st_nxt.bresp = RESP_OKAY;
        end
        default: begin
          st_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end
    st_nxt.aw_rdy = ~st_nxt.aw_got & ~st_nxt.bvalid;
    st_nxt.w_rdy  = ~st_nxt.w_got & ~st_nxt.bvalid;

    // Reads answer one cycle after the address is taken.
    if (st_r.rvalid && RREADY_I) begin
      st_nxt.rvalid = 1'b0;
    end
    if (ar_fire) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = RESP_OKAY;
      st_nxt.rdata  = '0;
      case (aridx)
        IDX_PIN_MODE:    st_nxt.rdata[NPIN-1:0] = st_r.alt;
        IDX_PIN_DIR:     st_nxt.rdata[NPIN-1:0] = st_r.dir;
        IDX_PIN_LEVEL:   st_nxt.rdata[NPIN-1:0] = lvl_s;
        IDX_NOTIFY_MASK: st_nxt.rdata[NPIN-1:0] = st_r.nmask;
        IDX_NOTIFY_FMT:  st_nxt.rdata[1:0] = st_r.fmt;
        IDX_INT_STATUS:  st_nxt.rdata[NEV-1:0] = st_r.istat;
        IDX_INT_MASK:    st_nxt.rdata[NEV-1:0] = st_r.imask;
        IDX_PIN_SET, IDX_PIN_CLEAR: st_nxt.rdata = '0;
        default:         st_nxt.rresp = RESP_SLVERR;
      endcase
    end
    st_nxt.ar_rdy = ~st_nxt.rvalid;

    // Output latch, then the pin drive mux between software and alternate logic.
    st_nxt.out    = ((st_r.out & ~lvl_wm) | (st_r.wdata[NPIN-1:0] & lvl_wm) | set_bits)
                    & ~clr_bits;
    st_nxt.pin_o  = (st_r.alt & ALT_OUT_I) | (~st_r.alt & st_nxt.out);
    st_nxt.pin_oe = (st_r.alt & ALT_OE_I) | (~st_r.alt & st_nxt.dir);

    // Previous samples; warm-up hides the reset value of the synchroniser.
    if (st_r.warm != WARM_CYC) begin
      st_nxt.warm = st_r.warm + 2'h1;
    end
    st_nxt.lvl_prev = lvl_s;
    st_nxt.brk_prev = BRK_I;

    // A trigger in the load cycle keeps the request pending.
    st_nxt.pend = (st_r.pend & ~load) | pin_trig | brk_trig;
    if (load) begin
      st_nxt.snap = st_r.chg;
    end
    // Delivered flags drop; changes of this cycle are kept.
    st_nxt.chg = (st_r.chg & ~(tx_done ? st_r.snap : '0)) | diff;

    // Sticky events, cleared by writing one; a new event wins the clear.
    st_nxt.istat = (st_r.istat & ~ist_clr) | {brk_rise, pin_trig, tx_done};
    st_nxt.irq   = |(st_nxt.istat & st_nxt.imask);
  end

  // State register; the clock enable freezes everything.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_r <= ST_RST;
    end else if (CE_I) begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign AWREADY_O   = st_r.aw_rdy;
  assign WREADY_O    = st_r.w_rdy;
  assign BVALID_O    = st_r.bvalid;
  assign BRESP_O     = st_r.bresp;
  assign ARREADY_O   = st_r.ar_rdy;
  assign RVALID_O    = st_r.rvalid;
  assign RRESP_O     = st_r.rresp;
  assign RDATA_O     = {16'h0000, st_r.rdata};
  assign PIN_O       = st_r.pin_o;
  assign PIN_OE_O    = st_r.pin_oe;
  assign ALT_SEL_O   = st_r.alt;
  assign IRQ_O       = st_r.irq;
  assign PKT_DATA_O  = tx_data;
  assign PKT_VALID_O = tx_valid;
  assign PKT_LAST_O  = tx_last;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  a_set_high: assert property (CE_I && set_bits != '0 |=>
    (st_r.out & $past(set_bits)) == $past(set_bits)) else $error("set did not raise pin");
  a_clear_low: assert property (CE_I && clr_bits != '0 |=>
    (st_r.out & $past(clr_bits)) == '0) else $error("clear did not lower pin");
  a_alt_kept: assert property (CE_I && wr_fire |=>
    ((st_r.out ^ $past(st_r.out)) & $past(st_r.alt)) == '0)
    else $error("alternate pin latch changed by write");
  a_input_kept: assert property (CE_I && wr_fire |=>
    ((st_r.out ^ $past(st_r.out)) & ~$past(st_r.dir)) == '0)
    else $error("input pin latch changed by write");
  a_level_read: assert property (CE_I && ar_fire && aridx == IDX_PIN_LEVEL |=>
    RVALID_O && RDATA_O[NPIN-1:0] == $past(lvl_s)) else $error("level read wrong");
  a_masked_quiet: assert property (CE_I && !st_r.pend && !brk_trig &&
    (diff & ~st_r.nmask) == '0 |=> !st_r.pend) else $error("packet raised without cause");
  a_break_pend: assert property (CE_I && brk_trig |=>
    st_r.pend || tx_busy) else $error("break did not trigger packet");
  a_std_header: assert property (CE_I && load && !st_r.fmt[FMT_VENDOR] |=>
    PKT_VALID_O && PKT_DATA_O == PKT_REQ_TYPE) else $error("standard header wrong");
  a_change_once: assert property (CE_I && tx_done && diff == '0 |=>
    (st_r.chg & $past(st_r.snap)) == '0) else $error("change flags not cleared");

  c_std_pkt: cover property (tx_done && !st_r.fmt[FMT_VENDOR]);
  c_vnd_pkt: cover property (tx_done && st_r.fmt[FMT_VENDOR]);
  c_brk_pkt: cover property (brk_trig ##1 st_r.pend);
endmodule // gpio_notify

// ### inc/gpio_notify_pkg.sv
package gpio_notify_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NPIN    = 10;
  localparam int ADDR_W  = 12;
  localparam int IDX_W   = ADDR_W - 2;
  localparam int REG_W   = 16;
  localparam int NEV     = 3;
  localparam int PKT_MAX = 10;
  localparam int LEN_W   = 4;

  // ----------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_PIN_MODE    = 10'h00C;
  localparam logic [IDX_W-1:0] IDX_PIN_DIR     = 10'h00D;
  localparam logic [IDX_W-1:0] IDX_PIN_SET     = 10'h00E;
  localparam logic [IDX_W-1:0] IDX_PIN_CLEAR   = 10'h00F;
  localparam logic [IDX_W-1:0] IDX_PIN_LEVEL   = 10'h010;
  localparam logic [IDX_W-1:0] IDX_NOTIFY_MASK = 10'h011;
  localparam logic [IDX_W-1:0] IDX_NOTIFY_FMT  = 10'h012;
  localparam logic [IDX_W-1:0] IDX_INT_STATUS  = 10'h020;
  localparam logic [IDX_W-1:0] IDX_INT_MASK    = 10'h021;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [NPIN-1:0] RST_PIN_MODE    = 10'h300;
  localparam logic [NPIN-1:0] RST_PIN_DIR     = 10'h000;
  localparam logic [NPIN-1:0] RST_PIN_OUT     = 10'h000;
  localparam logic [NPIN-1:0] RST_NOTIFY_MASK = 10'h100;
  localparam logic [1:0]      RST_NOTIFY_FMT  = 2'h0;
  localparam logic [NEV-1:0]  RST_INT_MASK    = 3'h0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FMT_VENDOR = 0;
  localparam int FMT_BREAK  = 1;
  localparam int EV_PKT     = 0;
  localparam int EV_CHG     = 1;
  localparam int EV_BRK     = 2;
  localparam int STD_OVR    = 6;
  localparam int STD_PAR    = 5;
  localparam int STD_FRM    = 4;
  localparam int STD_RING   = 3;
  localparam int STD_BRK    = 2;
  localparam int STD_DSR    = 1;
  localparam int STD_DCD    = 0;
  localparam int VND_OVR    = 3;
  localparam int VND_PAR    = 2;
  localparam int VND_FRM    = 1;
  localparam int VND_BRK    = 0;

  // ----------------------------------------------------------------
  // Packet constants, bus answers and timing
  // ----------------------------------------------------------------
  localparam logic [7:0]       PKT_REQ_TYPE     = 8'hA1;
  localparam logic [7:0]       PKT_SERIAL_STATE = 8'h20;
  localparam logic [15:0]      PKT_WVALUE       = 16'h0000;
  localparam logic [7:0]       PKT_IFACE        = 8'h00;
  localparam logic [15:0]      PKT_WLENGTH      = 16'h0002;
  localparam logic [LEN_W-1:0] PKT_STD_LEN      = 4'hA;
  localparam logic [LEN_W-1:0] PKT_VND_LEN      = 4'h5;
  localparam logic [1:0]       RESP_OKAY        = 2'h0;
  localparam logic [1:0]       RESP_SLVERR      = 2'h2;
  localparam logic [1:0]       WARM_CYC         = 2'h3;

  // Expands two byte strobes into a sixteen bit lane mask.
  function automatic logic [REG_W-1:0] lanes(input logic [1:0] strb);
    lanes = {{8{strb[1]}}, {8{strb[0]}}};
  endfunction

endpackage

// ### src/pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 10
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_st_t;

  sync_st_t st_r;
  sync_st_t st_nxt;

  // Two stages; only the second stage is read outside.
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
  end

  // State register.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.s2;
endmodule // pin_sync

// ### src/pkt_tx.sv
`timescale 1ns/100ps
module pkt_tx import gpio_notify_pkg::*; #(
  parameter int NBYTE = PKT_MAX
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               ce_i,
  input  wire logic               load_i,
  input  wire logic [8*NBYTE-1:0] buf_i,
  input  wire logic [LEN_W-1:0]   len_i,
  output logic      [7:0]         data_o,
  output logic                    valid_o,
  output logic                    last_o,
  input  wire logic               ready_i,
  output logic                    busy_o,
  output logic                    done_o
);
  typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;
  typedef struct packed {
    tx_state_t          state;
    logic [8*NBYTE-1:0] sh;
    logic [LEN_W-1:0]   left;
    logic               valid;
    logic               last;
    logic               done;
  } tx_st_t;

  localparam tx_st_t TX_RST = '{state: TX_IDLE, default: '0};

  tx_st_t st_r;
  tx_st_t st_nxt;

  // Shifts the packet out byte by byte, lowest byte first.
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    case (st_r.state)
      TX_IDLE: begin
        if (load_i) begin
          st_nxt.state = TX_SEND;
          st_nxt.sh    = buf_i;
          st_nxt.left  = len_i;
          st_nxt.valid = 1'b1;
          st_nxt.last  = (len_i == LEN_W'(1));
        end
      end
      TX_SEND: begin
        if (ready_i) begin
          st_nxt.sh   = st_r.sh >> 8;
          st_nxt.left = st_r.left - LEN_W'(1);
          st_nxt.last = (st_r.left == LEN_W'(2));
          if (st_r.last) begin
            st_nxt.state = TX_IDLE;
            st_nxt.valid = 1'b0;
            st_nxt.last  = 1'b0;
            st_nxt.done  = 1'b1;
          end
        end
      end
      default: begin
        st_nxt = TX_RST;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= TX_RST;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign data_o  = st_r.sh[7:0];
  assign valid_o = st_r.valid;
  assign last_o  = st_r.last;
  assign busy_o  = st_r.valid;
  assign done_o  = st_r.done;
endmodule // pkt_tx

// ### verification/pkt_host_model.sv
`timescale 1ns/100ps
// Host side of the interrupt endpoint; it stalls one cycle in three.
module pkt_host_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] data_i,
  input  wire logic       last_i,
  input  wire logic       valid_i,
  output logic            ready_o
);
  logic [1:0] cnt_r;
  logic [8:0] q[$];
  // Poll pattern and capture of each byte taken with its last flag.
  // A plain process, since the bench also empties the queue.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
      if (valid_i && ready_o) q.push_back({last_i, data_i});
    end
  end
  assign ready_o = (cnt_r != 2'h0);
endmodule // pkt_host_model

// ### verification/gpio_notify_tb_top.sv
`timescale 1ns/100ps
module gpio_notify_tb_top;
  import gpio_notify_pkg::*;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, brk = 0;
  logic awr, wrd, bv, arr, rv, pv, pl, prdy, irq;
  logic [ADDR_W-1:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rdat;
  logic [1:0] br, rr;
  logic [2:0] e3 = 3'h5;
  logic [NPIN-1:0] pin = '0, po, poe, asel;
  logic [7:0] pd;
  int err_count = 0, total_checks = 0;
  gpio_notify dut (.CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .AWADDR_I(awa), .AWVALID_I(awv),
    .AWREADY_O(awr), .WDATA_I(wd), .WSTRB_I(4'h3), .WVALID_I(wv), .WREADY_O(wrd),
    .BRESP_O(br), .BVALID_O(bv), .BREADY_I(bry), .ARADDR_I(ara), .ARVALID_I(arv),
    .ARREADY_O(arr), .RDATA_O(rdat), .RRESP_O(rr), .RVALID_O(rv), .RREADY_I(rry),
    .PIN_I(pin), .PIN_O(po), .PIN_OE_O(poe), .ALT_OUT_I(10'h000), .ALT_OE_I(10'h000),
    .ALT_SEL_O(asel), .OVR_I(e3[2]), .PAR_I(e3[1]), .FRM_I(e3[0]), .BRK_I(brk),
    .PKT_DATA_O(pd), .PKT_VALID_O(pv), .PKT_LAST_O(pl), .PKT_READY_I(prdy), .IRQ_O(irq));
  pkt_host_model host (.clk_i(clk), .rst_i(rst), .data_i(pd), .last_i(pl), .valid_i(pv),
    .ready_o(prdy));
  // Clock and watchdog.
  initial forever #5 clk = ~clk;
  initial begin
    #200000;
    err_count++;
    give_verdict;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [IDX_W-1:0] i, input logic [15:0] d);
    @(posedge clk);
    awa <= {i, 2'b00};
    wd <= {16'h0000, d};
    awv <= 1;
    wv <= 1;
    bry <= 1;
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
    end while (!bv);
    bry <= 0;
    chk("bresp", 32'h0, {30'h0, br});
  endtask
  task rd(input logic [IDX_W-1:0] i, input logic [15:0] e, input logic [1:0] r);
    @(posedge clk);
    ara <= {i, 2'b00};
    arv <= 1;
    rry <= 1;
    do begin
      @(posedge clk);
      if (arr) arv <= 0;
    end while (!rv);
    rry <= 0;
    chk("rdata", {16'h0000, e}, rdat);
    chk("rresp", {30'h0, r}, {30'h0, rr});
  endtask
  // Waits for a packet of n bytes and compares it with last flags, first byte highest in e.
  task pkt(input logic [79:0] e, input int n);
    for (int k = 0; k < 400 && host.q.size() < n; k++) @(posedge clk);
    chk("count", n, host.q.size());
    for (int k = 0; k < n; k++) chk("byte", {23'h0, k == n - 1, e[8*(n-1-k)+:8]}, host.q[k]);
    host.q.delete();
  endtask
  task t_pins;
    rd(IDX_NOTIFY_MASK, 16'h0100, 2'h0);
    rd(IDX_NOTIFY_FMT, 16'h0000, 2'h0);
    rd(IDX_PIN_SET, 16'h0000, 2'h0);
    rd(10'h3FF, 16'h0000, 2'h2);
    wr(IDX_NOTIFY_MASK, 16'h03FF);
    wr(IDX_PIN_DIR, 16'h030F);
    wr(IDX_PIN_SET, 16'hFFFF);
    repeat (2) @(posedge clk);
    chk("pin", 32'h00F, po);
    chk("oe", 32'h00F, poe);
    wr(IDX_PIN_MODE, 16'h0000);
    repeat (2) @(posedge clk);
    chk("pin", 32'h00F, po);
    chk("oe", 32'h30F, poe);
    wr(IDX_PIN_MODE, 16'h0300);
    rd(IDX_PIN_MODE, 16'h0300, 2'h0);
    rd(IDX_PIN_DIR, 16'h030F, 2'h0);
    chk("alt", 32'h300, asel);
    wr(IDX_PIN_CLEAR, 16'h0005);
    repeat (2) @(posedge clk);
    chk("pin", 32'h00A, po);
    wr(IDX_PIN_LEVEL, 16'h03F5);
    pin <= 10'h155;
    repeat (4) @(posedge clk);
    chk("pin", 32'h005, po);
    rd(IDX_PIN_LEVEL, 16'h0155, 2'h0);
    chk("count", 0, host.q.size());
    wr(IDX_PIN_DIR, 16'h0000);
    pin <= 10'h000;
  endtask
  task t_pkts;
    wr(IDX_NOTIFY_MASK, 16'h03DF);
    repeat (6) @(posedge clk);
    host.q.delete();
    pin <= 10'h02B;
    pkt(80'hA120_0000_0000_0200_5B00, 10);
    e3 <= 3'h2;
    wr(IDX_NOTIFY_FMT, 16'h0001);
    pin <= 10'h20B;
    pkt(80'h0B_02_20_02_04, 5);
    pin <= 10'h20A;
    repeat (30) @(posedge clk);
    chk("count", 0, host.q.size());
    wr(IDX_NOTIFY_FMT, 16'h0003);
    brk <= 1;
    pkt(80'h0A_02_01_00_05, 5);
    wr(IDX_INT_MASK, 16'h0007);
    repeat (2) @(posedge clk);
    chk("irq", 1, irq);
    wr(IDX_INT_STATUS, 16'h0007);
    repeat (3) @(posedge clk);
    chk("irq", 0, irq);
    rd(IDX_INT_STATUS, 16'h0000, 2'h0);
  endtask
  task give_verdict;
    $display("Checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Reset, then the scenarios in order.
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    t_pins;
    t_pkts;
    give_verdict;
  end
endmodule // gpio_notify_tb_top
